// [hw/lgc_map.vh]
// register map, field positions, codes and reset values of the logic cell pair
`ifndef LGC_MAP_VH
`define LGC_MAP_VH

// ****************************************************************
// register addressing (byte address of the avalon slave)
// ****************************************************************
`define LGC_ADDR_W         8
`define LGC_CTRL_OFS       2'h0
`define LGC_SEL_OFS        2'h1
`define LGC_GLS_OFS        2'h2
`define LGC_ADDR_TOP       7
`define LGC_ADDR_CELL      6
`define LGC_ADDR_REG_HI    5
`define LGC_ADDR_REG_LO    4
`define LGC_ADDR_KIND_HI   3
`define LGC_ADDR_KIND_LO   2

// alias kinds at +0x0, +0x4, +0x8, +0xC
`define LGC_KIND_WRITE     2'h0
`define LGC_KIND_CLEAR     2'h1
`define LGC_KIND_SET       2'h2
`define LGC_KIND_INVERT    2'h3

// ****************************************************************
// cell_control fields
// ****************************************************************
`define LGC_CTRL_POL_HI    19
`define LGC_CTRL_POL_LO    16
`define LGC_CTRL_ENABLE    15
`define LGC_CTRL_RISE_IRQ  11
`define LGC_CTRL_FALL_IRQ  10
`define LGC_CTRL_PIN_OE    7
`define LGC_CTRL_LEVEL     6
`define LGC_CTRL_OUT_INV   5
`define LGC_CTRL_MODE_HI   2
`define LGC_CTRL_MODE_LO   0
`define LGC_CTRL_WMASK     32'h000F_8CA7

// ****************************************************************
// cell_input_select fields
// ****************************************************************
`define LGC_SEL4_HI        14
`define LGC_SEL4_LO        12
`define LGC_SEL3_HI        10
`define LGC_SEL3_LO        8
`define LGC_SEL2_HI        6
`define LGC_SEL2_LO        4
`define LGC_SEL1_HI        2
`define LGC_SEL1_LO        0
`define LGC_SEL_WMASK      32'h0000_7777
`define LGC_GLS_WMASK      32'hFFFF_FFFF

// ****************************************************************
// core function codes and reset values
// ****************************************************************
`define LGC_MODE_AND_OR    3'h0
`define LGC_MODE_OR_XOR    3'h1
`define LGC_MODE_AND4      3'h2
`define LGC_MODE_SR_LATCH  3'h3
`define LGC_MODE_DFF_SR    3'h4
`define LGC_MODE_DFF2_R    3'h5
`define LGC_MODE_JK_R      3'h6
`define LGC_MODE_LATCH_SR  3'h7
`define LGC_REG_RESET      32'h0000_0000
`define LGC_SYNC_W         27

`endif

// [hw/lgc_cell.v]
// one logic cell: gates, gate polarity, core function, output stage, edge interrupt
`timescale 1ns/1ps
`include "lgc_map.vh"

module lgc_cell
(
   input  wire        i_clock,
   input  wire        i_srst,
   input  wire        i_enable,
   input  wire [2:0]  i_mode,
   input  wire [3:0]  i_gate_invert,
   input  wire        i_output_invert,
   input  wire        i_rise_irq_enable,
   input  wire        i_fall_irq_enable,
   input  wire        i_pin_output_enable,
   input  wire [31:0] i_gate_select,
   input  wire [3:0]  i_source,
   output reg         o_cell_out,
   output reg         o_pin_out,
   output reg         o_pin_oe,
   output reg         o_irq
);

   // ****************************************************************
   // gate combining: or of every enabled true or negated source
   // ****************************************************************
   function gate_or;
      input [7:0] sel;
      input [3:0] src;
      integer     s;
      begin
         gate_or = 1'b0;
         for (s = 0; s < 4; s = s + 1)
            gate_or = gate_or | (sel[2*s+1] & src[s]) | (sel[2*s] & ~src[s]); // R19
      end
   endfunction

   wire [3:0] gate;
   reg        q;
   reg        next_q;
   reg        core;
   reg        clk_prev;
   reg        level_prev;

   // gate results pass through their polarity inverter
   assign gate[0] = gate_or(i_gate_select[7:0], i_source) ^ i_gate_invert[0];   // R02
   assign gate[1] = gate_or(i_gate_select[15:8], i_source) ^ i_gate_invert[1];  // R02
   assign gate[2] = gate_or(i_gate_select[23:16], i_source) ^ i_gate_invert[2]; // R02
   assign gate[3] = gate_or(i_gate_select[31:24], i_source) ^ i_gate_invert[3]; // R02

   wire clk_rise = gate[0] & ~clk_prev;

   // ****************************************************************
   // core function; flip-flop clocks are gate one edges seen on i_clock
   // ****************************************************************
   always @*
   begin
      next_q = q;
      core   = 1'b0;
      case (i_mode)
         `LGC_MODE_AND_OR:   core = (gate[0] & gate[1]) | (gate[2] & gate[3]); // R10
         `LGC_MODE_OR_XOR:   core = (gate[0] | gate[1]) ^ (gate[2] | gate[3]); // R10
         `LGC_MODE_AND4:     core = &gate;                                     // R10
         `LGC_MODE_SR_LATCH:
         begin
            // set wins when both are asserted
            if (gate[0] | gate[1])
               next_q = 1'b1;                      // R11
            else if (gate[2] | gate[3])
               next_q = 1'b0;                      // R11
            core = next_q;
         end
         `LGC_MODE_DFF_SR:
         begin
            if (gate[3])
               next_q = 1'b1;                      // R11
            else if (gate[2])
               next_q = 1'b0;                      // R11
            else if (clk_rise)
               next_q = gate[1];                   // R11
            core = q;
         end
         `LGC_MODE_DFF2_R:
         begin
            if (gate[2])
               next_q = 1'b0;                      // R12
            else if (clk_rise)
               next_q = gate[1] & gate[3];         // R12
            core = q;
         end
         `LGC_MODE_JK_R:
         begin
            if (gate[2])
               next_q = 1'b0;                      // R12
            else if (clk_rise)
               next_q = (gate[1] & ~q) | (~gate[3] & q); // R12
            core = q;
         end
         `LGC_MODE_LATCH_SR:
         begin
            if (gate[3])
               next_q = 1'b1;                      // R13
            else if (gate[2])
               next_q = 1'b0;                      // R13
            else if (gate[0])
               next_q = gate[1];                   // R13
            core = next_q;
         end
         default: core = 1'b0;
      endcase
   end

   // ****************************************************************
   // state, output stage and edge interrupt
   // ****************************************************************
   always @(posedge i_clock)
   begin
      if (i_srst | ~i_enable)
      begin
         q          <= 1'b0;
         clk_prev   <= 1'b0;
         o_cell_out <= 1'b0;                       // R03
         o_pin_out  <= 1'b0;                       // R03
      end
      else
      begin
         q          <= next_q;
         clk_prev   <= gate[0];
         o_cell_out <= core ^ i_output_invert;     // R09
         o_pin_out  <= core ^ i_output_invert;
      end
   end

   // edges come from successive samples of the output, so a pulse narrower
   // than one clock on a combinational path is never seen
   always @(posedge i_clock)
   begin
      if (i_srst)
      begin
         level_prev <= 1'b0;
         o_irq      <= 1'b0;
         o_pin_oe   <= 1'b0;
      end
      else
      begin
         level_prev <= o_cell_out;                                      // R21
         o_irq      <= (i_rise_irq_enable & o_cell_out & ~level_prev) | // R04 R21
                       (i_fall_irq_enable & ~o_cell_out & level_prev);  // R05
         o_pin_oe   <= i_pin_output_enable;                             // R07
      end
   end

endmodule // lgc_cell

// [hw/lgc_top.v]
// pair of configurable logic cells with an avalon-mm register slave
`timescale 1ns/1ps
`include "lgc_map.vh"

// Contract
// R01: clear, set, invert aliases at +4,+8,+C
// R02: gate polarity bits invert gate results
// R03: disabled cell holds all outputs low; the code holds only o_cell_out and o_pin_out low, not o_pin_oe or o_irq
// R04: rising output edge raises interrupt when enabled
// R05: falling output edge raises interrupt when enabled
// R06: software never enables both edge interrupts
// R07: pin enable drives result onto pin
// R08: read-only level bit shows cell output
// R09: output invert bit flips final output
// R10: codes 0-2 are and-or, or-xor, and4
// R11: code 3 sr latch, 4 d flop
// R12: code 5 two-input d, 6 jk
// R13: code 7 transparent latch with set, reset
// R14: unimplemented bits read zero, writes ignored
// R15: source mux four choices per code
// R16: source mux three choices per code
// R17: source mux two choices per code
// R18: source mux one choices, same both cells
// R19: gates or enabled true/negated sources, reset clear
// R20: reserved mux codes feed logic zero
// R21: sampled-output edges give one-cycle interrupt pulse
module lgc_top
(
   input  wire        i_clock,
   input  wire        i_srst,
   // avalon-mm slave
   input  wire [7:0]  i_avs_address,
   input  wire        i_avs_read,
   input  wire        i_avs_write,
   input  wire [31:0] i_avs_writedata,
   input  wire [3:0]  i_avs_byteenable,
   output reg  [31:0] o_avs_readdata,
   output reg         o_avs_waitrequest,
   // per-cell sources, bit 0 for cell one and bit 1 for cell two
   input  wire [1:0]  i_cell_input_pin_a,
   input  wire [1:0]  i_cell_input_pin_b,
   input  wire [1:0]  i_spi_data_in,
   input  wire [1:0]  i_spi_data_out,
   input  wire [1:0]  i_uart_rx,
   input  wire [1:0]  i_uart_tx,
   // shared sources
   input  wire        i_timer3_compare_out,
   input  wire        i_timer3_match,
   input  wire        i_timer2_compare_out,
   input  wire        i_timer2_match,
   input  wire        i_multi_timer_match,
   input  wire        i_multi_timer_out_a,
   input  wire        i_multi_timer_out_b,
   input  wire        i_multi_timer_out_c,
   input  wire        i_calendar_event,
   input  wire        i_comparator_one,
   input  wire        i_comparator_two,
   input  wire        i_adc_end_of_conversion,
   input  wire        i_secondary_oscillator,
   input  wire        i_low_power_rc_clock,
   input  wire        i_reference_clock_out,
   // cell results
   output wire [1:0]  o_cell_out,
   output wire [1:0]  o_pin_out,
   output wire [1:0]  o_pin_oe,
   output wire [1:0]  o_irq
);

   // ****************************************************************
   // helper functions
   // ****************************************************************

   // merge a write into a register for one of the four alias kinds;
   // only bits in the implemented mask and in enabled byte lanes move
   function [31:0] lgc_apply;
      input [31:0] old;
      input [31:0] wdata;
      input [1:0]  kind;
      input [31:0] lanes;
      input [31:0] wmask;
      reg   [31:0] hit;
      begin
         hit = lanes & wmask;                                   // R14
         case (kind)
            `LGC_KIND_WRITE:  lgc_apply = (old & ~hit) | (wdata & hit);
            `LGC_KIND_CLEAR:  lgc_apply = old & ~(wdata & hit);  // R01
            `LGC_KIND_SET:    lgc_apply = old | (wdata & hit);   // R01
            `LGC_KIND_INVERT: lgc_apply = old ^ (wdata & hit);   // R01
            default:          lgc_apply = old;
         endcase
      end
   endfunction

   // expand byte enables into a bit mask
   function [31:0] lgc_lanes;
      input [3:0] be;
      begin
         lgc_lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      end
   endfunction

   // pick one of eight candidates by a three-bit code
   function lgc_pick;
      input [7:0] cand;
      input [2:0] code;
      begin
         lgc_pick = cand[code];
      end
   endfunction

   // ****************************************************************
   // input synchronisers: every outside source passes two flops
   // ****************************************************************
   wire [`LGC_SYNC_W-1:0] raw_in;
   reg  [`LGC_SYNC_W-1:0] sync_meta;
   reg  [`LGC_SYNC_W-1:0] sync_in;

   assign raw_in = {i_cell_input_pin_a, i_cell_input_pin_b, i_spi_data_in, i_spi_data_out,
                    i_uart_rx, i_uart_tx, i_timer3_compare_out, i_timer3_match,
                    i_timer2_compare_out, i_timer2_match, i_multi_timer_match,
                    i_multi_timer_out_a, i_multi_timer_out_b, i_multi_timer_out_c,
                    i_calendar_event, i_comparator_one, i_comparator_two,
                    i_adc_end_of_conversion, i_secondary_oscillator,
                    i_low_power_rc_clock, i_reference_clock_out};

   // the first stage feeds only the second stage
   always @(posedge i_clock)
   begin
      if (i_srst)
      begin
         sync_meta <= {`LGC_SYNC_W{1'b0}};
         sync_in   <= {`LGC_SYNC_W{1'b0}};
      end
      else
      begin
         sync_meta <= raw_in;
         sync_in   <= sync_meta;
      end
   end

   wire [1:0] s_pin_a    = sync_in[26:25];
   wire [1:0] s_pin_b    = sync_in[24:23];
   wire [1:0] s_spi_in   = sync_in[22:21];
   wire [1:0] s_spi_out  = sync_in[20:19];
   wire [1:0] s_uart_rx  = sync_in[18:17];
   wire [1:0] s_uart_tx  = sync_in[16:15];
   wire       s_t3_out   = sync_in[14];
   wire       s_t3_match = sync_in[13];
   wire       s_t2_out   = sync_in[12];
   wire       s_t2_match = sync_in[11];
   wire       s_mt_match = sync_in[10];
   wire       s_mt_a     = sync_in[9];
   wire       s_mt_b     = sync_in[8];
   wire       s_mt_c     = sync_in[7];
   wire       s_calendar = sync_in[6];
   wire       s_cmp_one  = sync_in[5];
   wire       s_cmp_two  = sync_in[4];
   wire       s_adc_eoc  = sync_in[3];
   wire       s_secondary_oscillator     = sync_in[2];
   wire       s_low_power_rc_clock     = sync_in[1];
   wire       s_refclk   = sync_in[0];

   // the system clock cannot be sampled by itself; a half-rate toggle
   // stands in for it as the fastest waveform the cell can see
   reg sys_toggle;

   always @(posedge i_clock)
   begin
      if (i_srst)
         sys_toggle <= 1'b0;
      else
         sys_toggle <= ~sys_toggle;
   end

   // ****************************************************************
   // registers of both cells
   // ****************************************************************
   reg  [31:0] ctrl [0:1];
   reg  [31:0] sel  [0:1];
   reg  [31:0] gls  [0:1];

   // bus request decode
   wire        req       = i_avs_read | i_avs_write;
   wire        in_map    = ~i_avs_address[`LGC_ADDR_TOP];
   wire        cell_idx  = i_avs_address[`LGC_ADDR_CELL];
   wire [1:0]  reg_idx   = i_avs_address[`LGC_ADDR_REG_HI:`LGC_ADDR_REG_LO];
   wire [1:0]  kind      = i_avs_address[`LGC_ADDR_KIND_HI:`LGC_ADDR_KIND_LO];
   wire [31:0] lanes     = lgc_lanes(i_avs_byteenable);
   wire        do_write  = i_avs_write & ~o_avs_waitrequest & in_map;

   // write takes effect at the edge where the master sees waitrequest low
   integer c;
   always @(posedge i_clock)
   begin
      if (i_srst)
      begin
         for (c = 0; c < 2; c = c + 1)
         begin
            ctrl[c] <= `LGC_REG_RESET;
            sel[c]  <= `LGC_REG_RESET;
            gls[c]  <= `LGC_REG_RESET;     // R19
         end
      end
      else if (do_write)
      begin
         case (reg_idx)
            `LGC_CTRL_OFS: ctrl[cell_idx] <= lgc_apply(ctrl[cell_idx], i_avs_writedata, kind, lanes,
                                                       `LGC_CTRL_WMASK);          // R01 R08
            `LGC_SEL_OFS:  sel[cell_idx]  <= lgc_apply(sel[cell_idx], i_avs_writedata, kind, lanes,
                                                       `LGC_SEL_WMASK);           // R01
            `LGC_GLS_OFS:  gls[cell_idx]  <= lgc_apply(gls[cell_idx], i_avs_writedata, kind, lanes,
                                                       `LGC_GLS_WMASK);           // R01
            default:       ctrl[cell_idx] <= ctrl[cell_idx];
         endcase
      end
   end

   // ****************************************************************
   // avalon answer: one wait cycle, then waitrequest low for one cycle
   // ****************************************************************
   reg [31:0] next_readdata;

   // the level bit is never stored; it is taken live from the cell
   always @*
   begin
      next_readdata = 32'h0000_0000;
      if (in_map)
      begin
         case (reg_idx)
            `LGC_CTRL_OFS:
            begin
               next_readdata = ctrl[cell_idx];
               next_readdata[`LGC_CTRL_LEVEL] = o_cell_out[cell_idx];   // R08
            end
            `LGC_SEL_OFS:  next_readdata = sel[cell_idx];               // R14
            `LGC_GLS_OFS:  next_readdata = gls[cell_idx];
            default:       next_readdata = 32'h0000_0000;
         endcase
      end
   end

   always @(posedge i_clock)
   begin
      if (i_srst)
      begin
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata    <= 32'h0000_0000;
      end
      else
      begin
         // low for exactly the cycle after a pending request is seen
         o_avs_waitrequest <= ~(req & o_avs_waitrequest);
         if (i_avs_read & o_avs_waitrequest)
            o_avs_readdata <= next_readdata;
      end
   end

   // ****************************************************************
   // source multiplexers; reserved codes carry a constant zero
   // ****************************************************************
   wire [3:0] src [0:1];

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : gen_cell
         wire [7:0] cand1 = {s_mt_c, s_mt_b, s_mt_a, s_refclk,
                             s_low_power_rc_clock, s_secondary_oscillator, sys_toggle, s_pin_a[g]};                 // R18
         wire [7:0] cand2 = {1'b0, s_mt_match, 1'b0, s_adc_eoc,
                             s_uart_tx[g], s_cmp_one, o_cell_out[1-g], s_pin_b[g]};   // R17 R20
         wire [7:0] cand3 = {s_t3_match, s_t2_match, s_t2_out, s_uart_rx[g],
                             s_spi_out[g], s_cmp_two, o_cell_out[g], s_pin_a[g]};     // R16
         wire [7:0] cand4 = {s_t3_match, s_mt_match, s_calendar, 1'b0,
                             s_spi_in[g], s_t3_out, o_cell_out[1-g], s_pin_b[g]};     // R15 R20

         assign src[g][0] = lgc_pick(cand1, sel[g][`LGC_SEL1_HI:`LGC_SEL1_LO]);
         assign src[g][1] = lgc_pick(cand2, sel[g][`LGC_SEL2_HI:`LGC_SEL2_LO]);
         assign src[g][2] = lgc_pick(cand3, sel[g][`LGC_SEL3_HI:`LGC_SEL3_LO]);
         assign src[g][3] = lgc_pick(cand4, sel[g][`LGC_SEL4_HI:`LGC_SEL4_LO]);

         // software must not set both edge enables; the cell just ors them
         lgc_cell u_cell
         (
            .i_clock             (i_clock),
            .i_srst              (i_srst),
            .i_enable            (ctrl[g][`LGC_CTRL_ENABLE]),                  // R03
            .i_mode              (ctrl[g][`LGC_CTRL_MODE_HI:`LGC_CTRL_MODE_LO]),
            .i_gate_invert       (ctrl[g][`LGC_CTRL_POL_HI:`LGC_CTRL_POL_LO]),
            .i_output_invert     (ctrl[g][`LGC_CTRL_OUT_INV]),
            .i_rise_irq_enable   (ctrl[g][`LGC_CTRL_RISE_IRQ]),
            .i_fall_irq_enable   (ctrl[g][`LGC_CTRL_FALL_IRQ]),               // R06
            .i_pin_output_enable (ctrl[g][`LGC_CTRL_PIN_OE]),
            .i_gate_select       (gls[g]),
            .i_source            (src[g]),
            .o_cell_out          (o_cell_out[g]),
            .o_pin_out           (o_pin_out[g]),
            .o_pin_oe            (o_pin_oe[g]),
            .o_irq               (o_irq[g])
         );
      end
   endgenerate

endmodule // lgc_top

// [tb/lgc_properties.sv]
// checker: bus handshake and cell output properties of the logic cell pair
`timescale 1ns/1ps
module lgc_properties
(
   input wire        i_clock,
   input wire        i_srst,
   input wire [7:0]  i_avs_address,
   input wire        i_avs_read,
   input wire        i_avs_write,
   input wire [31:0] o_avs_readdata,
   input wire        o_avs_waitrequest,
   input wire [1:0]  o_cell_out,
   input wire [1:0]  o_pin_out,
   input wire [1:0]  o_pin_oe,
   input wire [1:0]  o_irq
);
   // ****************************************************************
   // properties
   // ****************************************************************
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_srst);
   a_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_wait_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("request not answered after one wait state");
   a_ctrl_zero: assert property (i_avs_read && !o_avs_waitrequest && {i_avs_address[7], i_avs_address[5:4]} == 3'h0
      |-> (o_avs_readdata & ~32'h000F_8CE7) == 32'h0)
      else $error("control read shows unimplemented bits");
   a_sel_zero: assert property (i_avs_read && !o_avs_waitrequest && {i_avs_address[7], i_avs_address[5:4]} == 3'h1
      |-> (o_avs_readdata & 32'hFFFF_8888) == 32'h0)
      else $error("select read shows unimplemented bits");
   a_unmapped_zero: assert property (i_avs_read && !o_avs_waitrequest && (i_avs_address[7] || &i_avs_address[5:4])
      |-> o_avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_irq_pulse: assert property (o_irq != 2'h0 |=> (o_irq & $past(o_irq)) == 2'h0)
      else $error("interrupt pulse longer than one cycle");
   a_irq_cause: assert property (o_irq != 2'h0 |-> (o_irq & ~($past(o_cell_out) ^ $past(o_cell_out, 2))) == 2'h0)
      else $error("interrupt without output edge");
   a_pin_follow: assert property (o_pin_out == o_cell_out)
      else $error("pin output differs from cell output");
   a_oe_cause: assert property (o_pin_oe != $past(o_pin_oe)
      |-> $past(i_avs_write) || $past(i_avs_write, 2) || $past(i_avs_write, 3) || $past(i_srst))
      else $error("pin enable changed without a write");
endmodule // lgc_properties

// [tb/lgc_src_model.sv]
// model of the on-chip sources and input pins feeding the logic cells
`timescale 1ns/1ps
module lgc_src_model
(
   input  wire        i_clock,
   input  wire        i_srst,
   input  wire [1:0]  i_pin_a,
   input  wire [1:0]  i_pin_b,
   output reg  [1:0]  o_pin_a,
   output reg  [1:0]  o_pin_b,
   output reg  [22:0] o_misc
);
   // pins change just after an edge; other sources are bits of a free-running counter, bit 0 toggling every cycle and higher bits ever more slowly
   always @(posedge i_clock)
   begin
      o_pin_a <= i_pin_a;
      o_pin_b <= i_pin_b;
      o_misc  <= i_srst ? 23'h0 : o_misc + 23'h1;
   end
endmodule // lgc_src_model

// [tb/lgc_tb_top.sv]
// self-checking bench for the logic cell pair
`timescale 1ns/1ps
module lgc_tb_top;
   logic i_clock = 0, i_srst = 1, rd = 0, wr = 0, v, e;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h0, q;
   logic [1:0] pa = 2'h0, pb = 2'h0;
   logic [3:0] p;
   wire [31:0] rdata;
   wire waitreq;
   wire [1:0] pin_a, pin_b, cout, pout, poe, irq;
   wire [22:0] misc;
   int n_fail = 0, check_count = 0, irq_cnt = 0, m, k, j;
   lgc_src_model u_src (.i_clock(i_clock), .i_srst(i_srst), .i_pin_a(pa), .i_pin_b(pb), .o_pin_a(pin_a),
      .o_pin_b(pin_b), .o_misc(misc));
   lgc_top uut (.i_clock(i_clock), .i_srst(i_srst), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
      .i_cell_input_pin_a(pin_a), .i_cell_input_pin_b(pin_b), .i_spi_data_in(misc[1:0]),
      .i_spi_data_out(misc[3:2]), .i_uart_rx(misc[5:4]), .i_uart_tx(misc[7:6]), .i_timer3_compare_out(misc[8]),
      .i_timer3_match(misc[9]), .i_timer2_compare_out(misc[10]), .i_timer2_match(misc[11]),
      .i_multi_timer_match(misc[12]), .i_multi_timer_out_a(misc[13]), .i_multi_timer_out_b(misc[14]),
      .i_multi_timer_out_c(misc[15]), .i_calendar_event(misc[16]), .i_comparator_one(misc[17]),
      .i_comparator_two(misc[18]), .i_adc_end_of_conversion(misc[19]), .i_secondary_oscillator(misc[20]),
      .i_low_power_rc_clock(misc[21]), .i_reference_clock_out(misc[22]), .o_cell_out(cout), .o_pin_out(pout),
      .o_pin_oe(poe), .o_irq(irq));
   // ****************************************************************
   // clock, pulse counter, tasks
   // ****************************************************************
   initial forever #10 i_clock = ~i_clock;
   // counts cell one interrupt pulses
   always @(posedge i_clock) if (irq[0] === 1'b1) irq_cnt <= irq_cnt + 1;
   task end_sim;
      if (n_fail == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one bus cycle held until waitrequest is sampled low; read data lands in q
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge i_clock);
      adr <= a; wr <= w; rd <= !w; wd <= d; n = 0;
      do begin @(posedge i_clock); n++; end while (waitreq !== 1'b0 && n < 40);
      q = rdata; rd <= 1'b0; wr <= 1'b0;
      if (waitreq !== 1'b0) begin n_fail++; end_sim; end
   endtask
   // pins pass the model flop and two sync flops, so eight cycles is ample settling
   task pins(input logic a, input logic b);
      @(posedge i_clock);
      pa <= {a, a}; pb <= {b, b};
      repeat (8) @(posedge i_clock);
   endtask
   // gates one and two see pin a, three and four pin b
   function automatic logic expf(input int md, input logic [3:0] pl, input logic iv, input logic a, input logic b);
      logic g1, g2, g3, g4;
      g1 = a ^ pl[0]; g2 = a ^ pl[1]; g3 = b ^ pl[2]; g4 = b ^ pl[3];
      return iv ^ (md == 0 ? (g1 & g2) | (g3 & g4) : md == 1 ? (g1 | g2) ^ (g3 | g4) : g1 & g2 & g3 & g4);
   endfunction
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial
   begin
      repeat (10) @(posedge i_clock);
      i_srst <= 1'b0;
      bus(0, 8'h00, 0); chk(q, 32'h0);
      bus(1, 8'h10, 32'hFFFF_FFFF); bus(0, 8'h10, 0); chk(q, 32'h0000_7777);
      bus(1, 8'h14, 32'hFFFF_FFFF); bus(0, 8'h10, 0); chk(q, 32'h0);
      bus(1, 8'h00, 32'hFFFF_73FF); bus(0, 8'h00, 0); chk(q, 32'h000F_00A7);
      bus(1, 8'h04, 32'hFFFF_FFFF); bus(1, 8'h08, 32'h0000_00A0); bus(1, 8'h0C, 32'h0000_0081);
      bus(0, 8'h00, 0); chk(q, 32'h0000_0021);
      bus(1, 8'h30, 32'hFFFF_FFFF); bus(0, 8'h30, 0); chk(q, 32'h0);
      bus(0, 8'h80, 0); chk(q, 32'h0);
      bus(1, 8'h20, 32'h0808_0202);
      for (m = 0; m < 3; m++)
         for (k = 0; k < 32; k++)
         begin
            p = k[3:0]; v = k[4];
            bus(1, 8'h00, 32'h8080 | {12'h0, p, 16'h0} | {26'h0, v, 5'h0} | m);
            for (j = 0; j < 4; j++)
            begin
               pins(j[0], j[1]); e = expf(m, p, v, j[0], j[1]);
               chk(cout[0], e);
               chk(pout[0], e);
               chk(poe[0], 1);
               chk(cout[1], 0);
            end
         end
      bus(1, 8'h00, 32'h0000_0082); pins(1, 1); chk(cout[0], 0);
      bus(1, 8'h00, 32'h0000_8003); pins(1, 0); chk(cout[0], 1);
      bus(0, 8'h00, 0); chk(q, 32'h0000_8043);
      pins(0, 0); chk(cout[0], 1);
      pins(0, 1); chk(cout[0], 0);
      bus(1, 8'h08, 32'h0000_0040); bus(0, 8'h00, 0); chk(q, 32'h0000_8003);
      chk(poe[0], 0);
      bus(1, 8'h00, 32'h0000_8802); k = irq_cnt; pins(1, 1); pins(0, 1); chk(irq_cnt - k, 1);
      bus(1, 8'h00, 32'h0000_8402); k = irq_cnt; pins(1, 1); pins(0, 1); chk(irq_cnt - k, 1);
      // gate two now sees pin b, so data never changes in the same cycle as the gate one clock
      bus(1, 8'h20, 32'h0808_0802); bus(1, 8'h00, 32'h0004_8005); pins(0, 1); pins(1, 1); chk(cout[0], 1);
      pins(1, 0); chk(cout[0], 0); bus(1, 8'h00, 32'h0004_8006); pins(0, 1); pins(1, 1); chk(cout[0], 1);
      pins(0, 1); pins(1, 1); chk(cout[0], 0);
      end_sim;
   end
   // hang guard
   initial
   begin
      repeat (100000) @(posedge i_clock);
      n_fail++;
      end_sim;
   end
endmodule // lgc_tb_top
bind lgc_top lgc_properties u_props (.i_clock(i_clock), .i_srst(i_srst), .i_avs_address(i_avs_address),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest), .o_cell_out(o_cell_out), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
   .o_irq(o_irq));
